/* File: sfwp_protect.sv */
// Write-enable latch, protected-range decode and lock checks for serial flash
`timescale 1ns/1ps
// What this block does
// - Latch-set command sets the write-enable latch.
// - Power-up, software reset pair and latch-clear command clear the latch.
// - Status, upper-address and config register writes clear the latch afterwards.
// - Page write, sector/block/chip wipe and security writes clear the latch.
// - Unguarded nonvolatile lock set/clear-all and volatile lock write clear the latch.
// - Protect-level range is readable but refuses program and erase.
// - Guard bit set and guard pin low block status and nonvolatile lock writes.
// - In deep power-down only release and reset pair are obeyed.
// - Protected if range or the addressed volatile or nonvolatile lock entry says so; chip wipe checks range only.
// - Lowest and highest blocks lock per 4KB sector.
// - Middle blocks each have one lock entry for the whole block.
// - Flag 0: code n protects 2^(n-1) blocks, top or bottom; 11xx all.
// - Flag 1 protects the exact complement of the flag-0 region.
// - After power-on, enter continuous read as nv config byte 0 selects.
// - Continuous-read bits other than 1,0 end the power-on read mode.
// - Nonvolatile locks survive software reset but clear on reset_n; volatile locks refill on both.
// - Lock values 00H/FFH only; other volatile values ignored, latch kept.
// - Volatile locks load from nv config default bit at reset.
module sfwp_protect (
    input  wire logic                           clk,
    input  wire logic                           reset_n,
    input  wire logic                           soft_reset,
    input  wire logic                           cmd_valid,
    input  wire sfwp_pkg::sfwp_cmd_type         cmd_code,
    input  wire logic [sfwp_pkg::BLOCK_W-1:0]   cmd_block,
    input  wire logic [sfwp_pkg::SECTOR_W-1:0]  cmd_sector,
    input  wire logic [7:0]                     cmd_data,
    input  wire logic [4:0]                     new_protect_level,
    input  wire logic                           new_complement_flag,
    input  wire logic                           new_status_guard_bit0,
    input  wire logic                           write_guard_pin,
    input  wire logic [7:0]                     nv_config_byte0,
    input  wire logic [7:0]                     nv_config_byte2,
    input  wire logic                           read_frame_valid,
    input  wire logic [1:0]                     continuous_read_bits,
    output logic                                write_enable_latch,
    output logic [4:0]                          protect_level,
    output logic                                complement_flag,
    output logic                                status_guard_bit0,
    output logic                                boot_direct_read,
    output logic [7:0]                          boot_read_mode,
    output logic                                deep_power_down,
    output logic                                array_write_go,
    output logic                                cmd_rejected
);
    // Pin synchroniser for the guard pin
    logic guard_meta_reg;
    logic guard_sync_reg;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            guard_meta_reg <= 1'b1;
            guard_sync_reg <= 1'b1;
        end else begin
            guard_meta_reg <= write_guard_pin;
            guard_sync_reg <= guard_meta_reg;
        end
    end

    sfwp_lock_if vol_if ();
    sfwp_lock_if nv_if ();
    // Both lock stores are sfwp_lock_mem and clear on reset_n; only the volatile one refills on software reset
    sfwp_lock_mem u_vol (.clk(clk), .reset_n(reset_n), .port(vol_if.mem));
    sfwp_lock_mem u_nv  (.clk(clk), .reset_n(reset_n), .port(nv_if.mem));

    sfwp_pkg::sfwp_mode_type mode_reg;
    sfwp_pkg::sfwp_mode_type mode_next;
    logic        wel_reg;
    logic        wel_next;
    logic        reset_armed_reg;
    logic        init_reg;
    logic [4:0]  level_reg;
    logic        cmp_reg;
    logic        guard_bit_reg;
    logic        pend_reg;
    logic        pend_range_reg;
    logic        boot_reg;
    logic        deep_reg;
    logic        go_reg;
    logic        rej_reg;
    logic [7:0]  boot_mode_reg;

    // Edge blocks index per sector; middle blocks one entry each
    wire         is_low_block  = cmd_block == '0;
    wire         is_high_block = cmd_block == sfwp_pkg::TOP_BLOCK;
    wire [sfwp_pkg::LOCK_IDX_W-1:0] lock_idx =
        is_low_block  ? {8'h00, cmd_sector} :
        is_high_block ? (12'(sfwp_pkg::EDGE_SECTORS) + {8'h00, cmd_sector}) :
        (12'(sfwp_pkg::MID_BASE_IDX) + {1'b0, cmd_block} - 12'h001);

    // Flag-0 range: 2^(n-1) blocks from top or bottom, 11xx whole array
    wire [3:0]   code      = level_reg[3:0];
    wire         code_all  = code[3] && code[2];
    wire         code_none = code == sfwp_pkg::LEVEL_NONE;
    wire [11:0]  span      = (code > sfwp_pkg::LEVEL_MAX) ? 12'h000 : (12'h001 << (code - 4'h1));
    wire [11:0]  blk_ext   = {1'b0, cmd_block};
    wire         in_span   = level_reg[4] ? (blk_ext < span)
                                          : (blk_ext >= 12'(sfwp_pkg::BLOCK_COUNT) - span);
    wire         range_raw = code_all ? 1'b1 : (code_none ? 1'b0 : in_span);
    // Complement flag inverts the region exactly
    wire         range_hit = cmp_reg ? !range_raw : range_raw;

    wire         guarded = guard_bit_reg && !guard_sync_reg;

    wire         is_array_op = cmd_code == sfwp_pkg::SFWP_PAGE_WRITE
                            || cmd_code == sfwp_pkg::SFWP_UNIT_WIPE_4K
                            || cmd_code == sfwp_pkg::SFWP_BLOCK_WIPE;
    wire         is_modify = is_array_op
                            || cmd_code == sfwp_pkg::SFWP_CHIP_WIPE
                            || cmd_code == sfwp_pkg::SFWP_STATUS_WRITE
                            || cmd_code == sfwp_pkg::SFWP_UPPER_ADDR_WRITE
                            || cmd_code == sfwp_pkg::SFWP_NV_CONFIG_WRITE
                            || cmd_code == sfwp_pkg::SFWP_VOL_CONFIG_WRITE
                            || cmd_code == sfwp_pkg::SFWP_SEC_REG_WRITE
                            || cmd_code == sfwp_pkg::SFWP_NV_LOCK_SET
                            || cmd_code == sfwp_pkg::SFWP_NV_LOCK_CLEAR_ALL
                            || cmd_code == sfwp_pkg::SFWP_VOL_LOCK_WRITE;
    wire         deep_ok = mode_reg != sfwp_pkg::SFWP_DEEP
                        || cmd_code == sfwp_pkg::SFWP_DEEP_RELEASE
                        || cmd_code == sfwp_pkg::SFWP_RESET_ENABLE
                        || cmd_code == sfwp_pkg::SFWP_RESET_DO;
    wire         cmd_take  = cmd_valid && deep_ok && !pend_reg;
    // Latch must be set for any modifying command
    wire         mod_take  = cmd_take && is_modify && wel_reg;
    // Only 00H or FFH are legal volatile lock values
    wire         vl_legal  = cmd_data == sfwp_pkg::LOCK_OFF || cmd_data == sfwp_pkg::LOCK_ON;
    wire         vl_bad    = cmd_code == sfwp_pkg::SFWP_VOL_LOCK_WRITE && !vl_legal;
    wire         nv_guard  = guarded && (cmd_code == sfwp_pkg::SFWP_NV_LOCK_SET
                                      || cmd_code == sfwp_pkg::SFWP_NV_LOCK_CLEAR_ALL);
    wire         mod_ok    = mod_take && !vl_bad && !nv_guard;
    wire         sw_reset  = soft_reset || (cmd_take && reset_armed_reg
                                            && cmd_code == sfwp_pkg::SFWP_RESET_DO);
    // Any of range, volatile or nonvolatile lock protects
    wire         area_locked = pend_range_reg || vol_if.rd_val || nv_if.rd_val;

    assign vol_if.rd_idx    = lock_idx;
    assign nv_if.rd_idx     = lock_idx;
    assign vol_if.wr_en     = mod_ok && cmd_code == sfwp_pkg::SFWP_VOL_LOCK_WRITE;
    assign vol_if.wr_idx    = lock_idx;
    assign vol_if.wr_val    = cmd_data == sfwp_pkg::LOCK_ON;
    assign vol_if.clear_all = 1'b0;
    // Volatile locks take the configured default on reset
    assign vol_if.fill_all  = init_reg || sw_reset;
    assign vol_if.fill_val  = nv_config_byte2[sfwp_pkg::NVCFG_VL_DEFAULT_BIT];
    assign nv_if.wr_en      = mod_ok && cmd_code == sfwp_pkg::SFWP_NV_LOCK_SET;
    assign nv_if.wr_idx     = lock_idx;
    assign nv_if.wr_val     = 1'b1;
    assign nv_if.clear_all  = mod_ok && cmd_code == sfwp_pkg::SFWP_NV_LOCK_CLEAR_ALL;
    assign nv_if.fill_all   = 1'b0;
    assign nv_if.fill_val   = 1'b0;

    always_comb begin
        wel_next = wel_reg;
        if (sw_reset) begin
            // Software reset pair clears the latch
            wel_next = 1'b0;
        end else if (pend_reg) begin
            // Array operations clear the latch when they finish
            wel_next = 1'b0;
        end else if (cmd_take && cmd_code == sfwp_pkg::SFWP_LATCH_SET) begin
            wel_next = 1'b1;
        end else if (cmd_take && cmd_code == sfwp_pkg::SFWP_LATCH_CLEAR) begin
            wel_next = 1'b0;
        end else if (mod_ok && !is_array_op) begin
            // Register writes clear; lock writes clear
            wel_next = 1'b0;
        end
    end

    always_comb begin
        mode_next = mode_reg;
        case (mode_reg)
            sfwp_pkg::SFWP_BOOT_READ: begin
                // Mode bits other than 1,0 leave continuous read
                if (read_frame_valid && continuous_read_bits != sfwp_pkg::CREAD_KEEP) begin
                    mode_next = sfwp_pkg::SFWP_ACTIVE;
                end
            end
            sfwp_pkg::SFWP_ACTIVE: begin
                if (cmd_take && cmd_code == sfwp_pkg::SFWP_DEEP_DOWN) begin
                    mode_next = sfwp_pkg::SFWP_DEEP;
                end
            end
            default: begin
                if (cmd_take && cmd_code == sfwp_pkg::SFWP_DEEP_RELEASE) begin
                    mode_next = sfwp_pkg::SFWP_ACTIVE;
                end
            end
        endcase
        if (sw_reset) begin
            mode_next = sfwp_pkg::SFWP_ACTIVE;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_reg <= sfwp_pkg::SFWP_BOOT_READ;
            wel_reg  <= 1'b0;
            init_reg <= 1'b1;
            boot_reg <= 1'b1;
            deep_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            wel_reg  <= wel_next;
            init_reg <= 1'b0;
            boot_reg <= mode_next == sfwp_pkg::SFWP_BOOT_READ;
            deep_reg <= mode_next == sfwp_pkg::SFWP_DEEP;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            boot_mode_reg <= 8'h00;
        end else if (init_reg) begin
            boot_mode_reg <= nv_config_byte0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_armed_reg <= 1'b0;
        end else if (cmd_take) begin
            reset_armed_reg <= cmd_code == sfwp_pkg::SFWP_RESET_ENABLE;
        end
    end

    // Guarded status write keeps level, complement and guard bits
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            level_reg     <= 5'h00;
            cmp_reg       <= 1'b0;
            guard_bit_reg <= 1'b0;
        end else if (mod_ok && cmd_code == sfwp_pkg::SFWP_STATUS_WRITE && !guarded) begin
            level_reg     <= new_protect_level;
            cmp_reg       <= new_complement_flag;
            guard_bit_reg <= new_status_guard_bit0;
        end
    end

    // Array operations wait one cycle for the registered lock lookup
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pend_reg       <= 1'b0;
            pend_range_reg <= 1'b0;
        end else begin
            pend_reg       <= mod_ok && is_array_op;
            pend_range_reg <= range_hit;
        end
    end

    // Protected target rejected; latch-clear modify rejected
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            go_reg  <= 1'b0;
            rej_reg <= 1'b0;
        end else begin
            go_reg  <= pend_reg && !area_locked;
            rej_reg <= (pend_reg && area_locked)
                    || (cmd_take && is_modify && !mod_ok)
                    || (mod_ok && cmd_code == sfwp_pkg::SFWP_CHIP_WIPE
                        && !(cmp_reg ? code_all : code_none));
        end
    end

    assign write_enable_latch = wel_reg;
    assign protect_level      = level_reg;
    assign complement_flag    = cmp_reg;
    assign status_guard_bit0  = guard_bit_reg;
    assign boot_direct_read   = boot_reg;
    assign boot_read_mode     = boot_mode_reg;
    assign deep_power_down    = deep_reg;
    assign array_write_go     = go_reg;
    assign cmd_rejected       = rej_reg;

    a_latch_set: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_take && cmd_code == sfwp_pkg::SFWP_LATCH_SET && !sw_reset && !pend_reg
        |=> wel_reg) else $error("latch not set");
    a_latch_clear: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_take && cmd_code == sfwp_pkg::SFWP_LATCH_CLEAR |=> !wel_reg)
        else $error("latch not cleared");
    a_reg_write_clear: assert property (@(posedge clk) disable iff (!reset_n)
        mod_ok && cmd_code == sfwp_pkg::SFWP_STATUS_WRITE |=> !wel_reg)
        else $error("status write left latch set");
    sequence s_array_take;
        mod_ok && is_array_op;
    endsequence
    a_array_clear: assert property (@(posedge clk) disable iff (!reset_n)
        s_array_take |=> ##1 !wel_reg) else $error("array op left latch");
    a_vl_bad_keep: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_take && vl_bad && wel_reg && !sw_reset |=> wel_reg && $stable(u_vol.lock_reg))
        else $error("bad volatile value acted on");
    a_guard_hold: assert property (@(posedge clk) disable iff (!reset_n)
        guarded |=> $stable(level_reg) && $stable(cmp_reg)) else $error("guarded write");
    a_deep_filter: assert property (@(posedge clk) disable iff (!reset_n)
        mode_reg == sfwp_pkg::SFWP_DEEP && !deep_ok && !soft_reset |=> wel_reg == $past(wel_reg))
        else $error("command obeyed in deep power-down");
    a_no_wel_ignore: assert property (@(posedge clk) disable iff (!reset_n)
        cmd_take && is_array_op && !wel_reg |=> ##1 !go_reg) else $error("write without latch");
    a_locked_reject: assert property (@(posedge clk) disable iff (!reset_n)
        pend_reg && area_locked |=> cmd_rejected && !array_write_go)
        else $error("protected area written");
endmodule

/* File: sfwp_pkg.sv */
// Shared constants and types for the flash write-protection block
package sfwp_pkg;
    localparam int BLOCK_COUNT   = 2048;
    localparam int BLOCK_W       = 11;
    localparam int SECTOR_W      = 4;
    localparam int EDGE_SECTORS  = 16;
    localparam int LOCK_ENTRIES  = 2078;
    localparam int LOCK_IDX_W    = 12;
    localparam int MID_BASE_IDX  = 32;
    localparam logic [BLOCK_W-1:0] TOP_BLOCK = 11'h7FF;
    localparam logic [7:0] LOCK_OFF      = 8'h00;
    localparam logic [7:0] LOCK_ON       = 8'hFF;
    localparam logic [1:0] CREAD_KEEP    = 2'h2;
    localparam logic [3:0] LEVEL_NONE    = 4'h0;
    localparam logic [3:0] LEVEL_MAX     = 4'hB;
    localparam int NVCFG_VL_DEFAULT_BIT  = 2;

    typedef enum logic [4:0] {
        SFWP_NOP, SFWP_LATCH_SET, SFWP_LATCH_CLEAR, SFWP_STATUS_WRITE, SFWP_UPPER_ADDR_WRITE,
        SFWP_NV_CONFIG_WRITE, SFWP_VOL_CONFIG_WRITE, SFWP_PAGE_WRITE, SFWP_UNIT_WIPE_4K,
        SFWP_BLOCK_WIPE, SFWP_CHIP_WIPE, SFWP_SEC_REG_WRITE, SFWP_NV_LOCK_SET,
        SFWP_NV_LOCK_CLEAR_ALL, SFWP_VOL_LOCK_WRITE, SFWP_DEEP_DOWN, SFWP_DEEP_RELEASE,
        SFWP_RESET_ENABLE, SFWP_RESET_DO
    } sfwp_cmd_type;

    typedef enum logic [1:0] {SFWP_BOOT_READ, SFWP_ACTIVE, SFWP_DEEP} sfwp_mode_type;
endpackage

/* File: sfwp_lock_if.sv */
// Port bundle between control and the lock-entry memory
`timescale 1ns/1ps
interface sfwp_lock_if;
    logic                               wr_en;
    logic [sfwp_pkg::LOCK_IDX_W-1:0]    wr_idx;
    logic                               wr_val;
    logic                               clear_all;
    logic                               fill_all;
    logic                               fill_val;
    logic [sfwp_pkg::LOCK_IDX_W-1:0]    rd_idx;
    logic                               rd_val;
    modport ctrl (output wr_en, wr_idx, wr_val, clear_all, fill_all, fill_val, rd_idx,
                  input rd_val);
    modport mem (input wr_en, wr_idx, wr_val, clear_all, fill_all, fill_val, rd_idx,
                 output rd_val);
endinterface

/* File: sfwp_lock_mem.sv */
// One-bit-per-entry lock memory with bulk clear/fill and registered read
`timescale 1ns/1ps
module sfwp_lock_mem (
    input  wire logic   clk,
    input  wire logic   reset_n,
    sfwp_lock_if.mem    port
);
    logic [sfwp_pkg::LOCK_ENTRIES-1:0] lock_reg;
    logic                              rd_reg;

    genvar i;
    generate
        for (i = 0; i < sfwp_pkg::LOCK_ENTRIES; i++) begin : g_entry
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    lock_reg[i] <= 1'b0;
                end else if (port.fill_all) begin
                    lock_reg[i] <= port.fill_val;
                end else if (port.clear_all) begin
                    lock_reg[i] <= 1'b0;
                end else if (port.wr_en && port.wr_idx == i) begin
                    lock_reg[i] <= port.wr_val;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_reg <= 1'b0;
        end else begin
            rd_reg <= lock_reg[port.rd_idx];
        end
    end
    assign port.rd_val = rd_reg;
endmodule

/* File: sfwp_host_model.sv */
// Host controller model issuing decoded commands and boot read frames
`timescale 1ns/1ps
module sfwp_host_model (
    input  wire logic              clk,
    output sfwp_pkg::sfwp_cmd_type cmd_code,
    output logic                   soft_reset,
    output logic                   cmd_valid,
    output logic [10:0]            cmd_block,
    output logic [3:0]             cmd_sector,
    output logic [7:0]             cmd_data,
    output logic                   read_frame_valid,
    output logic [1:0]             continuous_read_bits
);
    initial begin
        cmd_code = sfwp_pkg::SFWP_NOP;
        {soft_reset, cmd_valid, read_frame_valid} = 3'h0;
        {cmd_block, cmd_sector, cmd_data, continuous_read_bits} = 25'h0;
    end

    // Fields toggle once released so stale values never look valid
    task automatic send(input sfwp_pkg::sfwp_cmd_type c, input logic [22:0] f);
        @(posedge clk);
        #1;
        cmd_code = c;
        {cmd_block, cmd_sector, cmd_data} = f;
        cmd_valid = 1'h1;
        @(posedge clk);
        #1;
        cmd_valid = 1'h0;
        cmd_code = sfwp_pkg::sfwp_cmd_type'(~c);
        {cmd_block, cmd_sector, cmd_data} = ~f;
    endtask

    task automatic boot_frame(input logic [1:0] m);
        @(posedge clk);
        #1;
        read_frame_valid = 1'h1;
        continuous_read_bits = m;
        @(posedge clk);
        #1;
        read_frame_valid = 1'h0;
        continuous_read_bits = ~m;
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic pulse_reset();
        @(posedge clk);
        #1;
        soft_reset = 1'h1;
        @(posedge clk);
        #1;
        soft_reset = 1'h0;
        repeat (2) @(posedge clk);
        #1;
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the flash write-protection block
`timescale 1ns/1ps
module tb_top;
    typedef struct packed {
        logic [4:0]  lvl;
        logic        cmp;
        logic [10:0] blk;
        logic        prot;
    } sfwp_row_type;
    sfwp_row_type           rows [14];
    sfwp_pkg::sfwp_cmd_type clr [12];
    sfwp_pkg::sfwp_cmd_type cmd_code;
    logic                   clk = 1'h0;
    logic                   reset_n = 1'h0;
    logic                   soft_reset, cmd_valid, read_frame_valid;
    logic [10:0]            cmd_block;
    logic [3:0]             cmd_sector;
    logic [7:0]             cmd_data, boot_read_mode;
    logic [1:0]             continuous_read_bits;
    logic [4:0]             new_protect_level = 5'h00, protect_level;
    logic                   new_complement_flag = 1'h0, new_status_guard_bit0 = 1'h0;
    logic                   write_guard_pin = 1'h1;
    logic [7:0]             nv_config_byte0 = 8'h00, nv_config_byte2 = 8'h00;
    logic                   write_enable_latch, complement_flag, status_guard_bit0;
    logic                   boot_direct_read, deep_power_down, array_write_go, cmd_rejected;
    logic                   go_seen, rej_seen;
    int                     failures = 0;
    int                     tests_run = 0;

    always #5 clk = ~clk;

    sfwp_protect DUT (.clk, .reset_n, .soft_reset, .cmd_valid, .cmd_code, .cmd_block,
        .cmd_sector, .cmd_data, .new_protect_level, .new_complement_flag,
        .new_status_guard_bit0, .write_guard_pin, .nv_config_byte0, .nv_config_byte2,
        .read_frame_valid, .continuous_read_bits, .write_enable_latch, .protect_level,
        .complement_flag, .status_guard_bit0, .boot_direct_read, .boot_read_mode,
        .deep_power_down, .array_write_go, .cmd_rejected);

    sfwp_host_model host (.clk, .cmd_code, .soft_reset, .cmd_valid, .cmd_block,
        .cmd_sector, .cmd_data, .read_frame_valid, .continuous_read_bits);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic do_reset(input logic [7:0] b0, input logic [7:0] b2);
        reset_n = 1'h0;
        nv_config_byte0 = b0;
        nv_config_byte2 = b2;
        repeat (10) @(posedge clk);
        #1;
        reset_n = 1'h1;
        @(posedge clk);
        #1;
    endtask

    // Go and reject pulses are caught anywhere in the answer window
    task automatic issue(input sfwp_pkg::sfwp_cmd_type c, input logic [22:0] f);
        host.send(c, f);
        go_seen = 1'h0;
        rej_seen = 1'h0;
        repeat (4) begin
            go_seen = go_seen | array_write_go;
            rej_seen = rej_seen | cmd_rejected;
            @(posedge clk);
            #1;
        end
    endtask

    task automatic armed(input sfwp_pkg::sfwp_cmd_type c, input logic [22:0] f);
        issue(sfwp_pkg::SFWP_LATCH_SET, 23'h0);
        issue(c, f);
    endtask

    task automatic try_write(input sfwp_pkg::sfwp_cmd_type c, input logic [22:0] f,
                             input logic ok);
        armed(c, f);
        check({7'h0, go_seen}, {7'h0, ok});
        check({7'h0, rej_seen}, {7'h0, ~ok});
        check({7'h0, write_enable_latch}, 8'h00);
    endtask

    task automatic set_level(input logic [4:0] l, input logic c, input logic g);
        {new_protect_level, new_complement_flag, new_status_guard_bit0} = {l, c, g};
        armed(sfwp_pkg::SFWP_STATUS_WRITE, 23'h0);
        {new_protect_level, new_complement_flag, new_status_guard_bit0} = ~{l, c, g};
    endtask

    initial begin
        rows = '{'{5'h00, 1'h0, 11'h7FF, 1'h0}, '{5'h01, 1'h0, 11'h7FF, 1'h1},
            '{5'h01, 1'h0, 11'h7FE, 1'h0}, '{5'h0B, 1'h0, 11'h400, 1'h1},
            '{5'h0B, 1'h0, 11'h3FF, 1'h0}, '{5'h05, 1'h0, 11'h7F0, 1'h1},
            '{5'h11, 1'h0, 11'h000, 1'h1}, '{5'h11, 1'h0, 11'h001, 1'h0},
            '{5'h1B, 1'h0, 11'h3FF, 1'h1}, '{5'h0C, 1'h0, 11'h000, 1'h1},
            '{5'h00, 1'h1, 11'h005, 1'h1}, '{5'h01, 1'h1, 11'h7FE, 1'h1},
            '{5'h01, 1'h1, 11'h7FF, 1'h0}, '{5'h0F, 1'h1, 11'h003, 1'h0}};
        clr = '{sfwp_pkg::SFWP_STATUS_WRITE, sfwp_pkg::SFWP_UPPER_ADDR_WRITE,
            sfwp_pkg::SFWP_NV_CONFIG_WRITE, sfwp_pkg::SFWP_VOL_CONFIG_WRITE,
            sfwp_pkg::SFWP_PAGE_WRITE, sfwp_pkg::SFWP_UNIT_WIPE_4K, sfwp_pkg::SFWP_BLOCK_WIPE,
            sfwp_pkg::SFWP_CHIP_WIPE, sfwp_pkg::SFWP_SEC_REG_WRITE, sfwp_pkg::SFWP_NV_LOCK_SET,
            sfwp_pkg::SFWP_NV_LOCK_CLEAR_ALL, sfwp_pkg::SFWP_VOL_LOCK_WRITE};
        do_reset(8'hA5, 8'h00);
        check({7'h0, boot_direct_read}, 8'h01);
        check(boot_read_mode, 8'hA5);
        check({7'h0, write_enable_latch}, 8'h00);
        host.boot_frame(2'h2);
        check({7'h0, boot_direct_read}, 8'h01);
        host.boot_frame(2'h1);
        check({7'h0, boot_direct_read}, 8'h00);
        $display("test boot read done");
        issue(sfwp_pkg::SFWP_LATCH_SET, 23'h0);
        check({7'h0, write_enable_latch}, 8'h01);
        issue(sfwp_pkg::SFWP_LATCH_CLEAR, 23'h0);
        check({7'h0, write_enable_latch}, 8'h00);
        issue(sfwp_pkg::SFWP_PAGE_WRITE, {11'h005, 12'h000});
        check({7'h0, go_seen}, 8'h00);
        foreach (clr[i]) begin
            armed(clr[i], {11'h3E8, 12'h000});
            check({7'h0, write_enable_latch}, 8'h00);
        end
        $display("test latch done");
        foreach (rows[i]) begin
            set_level(rows[i].lvl, rows[i].cmp, 1'h0);
            try_write(sfwp_pkg::SFWP_PAGE_WRITE, {rows[i].blk, 12'h000},
                      ~rows[i].prot);
        end
        set_level(5'h01, 1'h0, 1'h0);
        try_write(sfwp_pkg::SFWP_CHIP_WIPE, 23'h0, 1'h0);
        set_level(5'h00, 1'h0, 1'h0);
        $display("test range done");
        armed(sfwp_pkg::SFWP_VOL_LOCK_WRITE, {11'h064, 4'h0, 8'h5A});
        check({7'h0, write_enable_latch}, 8'h01);
        issue(sfwp_pkg::SFWP_VOL_LOCK_WRITE, {11'h064, 4'h0, 8'hFF});
        check({7'h0, write_enable_latch}, 8'h00);
        try_write(sfwp_pkg::SFWP_PAGE_WRITE, {11'h064, 12'h000}, 1'h0);
        try_write(sfwp_pkg::SFWP_PAGE_WRITE, {11'h065, 12'h000}, 1'h1);
        armed(sfwp_pkg::SFWP_VOL_LOCK_WRITE, {11'h000, 4'h3, 8'hFF});
        try_write(sfwp_pkg::SFWP_UNIT_WIPE_4K, {11'h000, 4'h3, 8'h00}, 1'h0);
        try_write(sfwp_pkg::SFWP_UNIT_WIPE_4K, {11'h000, 4'h4, 8'h00}, 1'h1);
        armed(sfwp_pkg::SFWP_NV_LOCK_SET, {11'h7FF, 4'hF, 8'hFF});
        try_write(sfwp_pkg::SFWP_UNIT_WIPE_4K, {11'h7FF, 4'hF, 8'h00}, 1'h0);
        try_write(sfwp_pkg::SFWP_UNIT_WIPE_4K, {11'h7FF, 4'hE, 8'h00}, 1'h1);
        armed(sfwp_pkg::SFWP_NV_LOCK_CLEAR_ALL, 23'h0);
        try_write(sfwp_pkg::SFWP_UNIT_WIPE_4K, {11'h7FF, 4'hF, 8'h00}, 1'h1);
        $display("test locks done");
        set_level(5'h00, 1'h0, 1'h1);
        check({7'h0, status_guard_bit0}, 8'h01);
        write_guard_pin = 1'h0;
        set_level(5'h0B, 1'h1, 1'h1);
        check({2'h0, protect_level, complement_flag}, 8'h00);
        armed(sfwp_pkg::SFWP_NV_LOCK_SET, {11'h0C8, 4'h0, 8'hFF});
        try_write(sfwp_pkg::SFWP_PAGE_WRITE, {11'h0C8, 12'h000}, 1'h1);
        write_guard_pin = 1'h1;
        set_level(5'h00, 1'h0, 1'h0);
        check({7'h0, status_guard_bit0}, 8'h00);
        $display("test guard done");
        issue(sfwp_pkg::SFWP_DEEP_DOWN, 23'h0);
        check({7'h0, deep_power_down}, 8'h01);
        issue(sfwp_pkg::SFWP_LATCH_SET, 23'h0);
        check({7'h0, write_enable_latch}, 8'h00);
        issue(sfwp_pkg::SFWP_DEEP_RELEASE, 23'h0);
        check({7'h0, deep_power_down}, 8'h00);
        armed(sfwp_pkg::SFWP_RESET_ENABLE, 23'h0);
        issue(sfwp_pkg::SFWP_RESET_DO, 23'h0);
        check({7'h0, write_enable_latch}, 8'h00);
        host.boot_frame(2'h0);
        issue(sfwp_pkg::SFWP_DEEP_DOWN, 23'h0);
        issue(sfwp_pkg::SFWP_RESET_ENABLE, 23'h0);
        issue(sfwp_pkg::SFWP_RESET_DO, 23'h0);
        check({7'h0, deep_power_down}, 8'h00);
        issue(sfwp_pkg::SFWP_LATCH_SET, 23'h0);
        host.pulse_reset();
        check({7'h0, write_enable_latch}, 8'h00);
        $display("test deep and reset done");
        do_reset(8'h3C, 8'h04);
        check(boot_read_mode, 8'h3C);
        check({7'h0, boot_direct_read}, 8'h01);
        host.boot_frame(2'h3);
        try_write(sfwp_pkg::SFWP_PAGE_WRITE, {11'h1F4, 12'h000}, 1'h0);
        $display("test lock default done");
        stop_test();
    end

    initial begin
        #200000;
        failures++;
        $display("watchdog expired");
        stop_test();
    end
endmodule
